// ### hdl/pfe_row_erase.sv
// program flash row erase sequencer with wishbone register slave
// assumes a flash array that erases the row given while erase_o.req
// stands, and a core that halts while stall_o is high
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
`include "pfe_map.svh"

// Function
// - The erase always covers a whole row, low address bits ignored.
// - Only 55h then aa into the unlock register enables a start.
// - Setting go after the unlock, with arm and erase set and cfg select clear in the same write, starts the row erase.
// - Two cycles of setup follow the go write before the erase.
// - The core is halted for the erase time of 2 ms.
// - Clocks and peripherals keep running during the stall.
// - Execution resumes at the third instruction after the go write.
// - Top bit of address high and control registers reads as one.
module pfe_row_erase #(
  parameter int unsigned ERASE_CYC = `PFE_ERASE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire pfe_pkg::pfe_wb_req_t wb_i,
  output pfe_pkg::pfe_wb_rsp_t wb_o,
  // core and flash array
  output logic stall_o,
  output pfe_pkg::pfe_erase_t erase_o,
  output logic busy_o
);
  import pfe_pkg::*;

  // ============================================================
  // registers
  logic [7:0] addr_low;
  logic [6:0] addr_high;
  logic cfg_sel, lat_only, erase_sel, fault, arm, go;
  logic [1:0] key_stage;
  logic ack;
  logic [31:0] rdat;
  pfe_state_t state;
  logic [31:0] cnt;

  // bus strobes
  logic req, wr;
  logic [7:0] wbyte;
  assign req = wb_i.cyc & wb_i.stb & ~ack;
  assign wr = req & wb_i.we & wb_i.sel[0];
  assign wbyte = wb_i.dat[7:0];

  function automatic logic hit(input logic [11:0] idx);
    hit = (wb_i.adr == idx);
  endfunction

  // go write that is allowed to start
  logic start;
  assign start = wr && hit(`PFE_IDX_CONTROL) && wbyte[`PFE_BIT_GO]
    && !go && key_stage == 2'd2 && wbyte[`PFE_BIT_ARM]
    && wbyte[`PFE_BIT_ERASE] && !wbyte[`PFE_BIT_CFGSEL];

  // ============================================================
  // ack, one cycle per request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req;
    end
  end

  // read data mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat <= 32'h0;
    end else if (req && !wb_i.we) begin
      case (wb_i.adr)
        `PFE_IDX_ADDR_LOW: rdat <= {24'h0, addr_low};
        `PFE_IDX_ADDR_HIGH: rdat <= {24'h0, 1'b1, addr_high};
        `PFE_IDX_CONTROL: rdat <= {24'h0, 1'b1, cfg_sel, lat_only,
          erase_sel, fault, arm, go, 1'b0};
        default: rdat <= 32'h0;
      endcase
    end
  end

  assign wb_o.ack = ack;
  assign wb_o.dat = rdat;

  // ============================================================
  // address registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_low <= `PFE_RST_ADDR_LOW;
      addr_high <= 7'h0;
    end else if (wr && state == PFE_IDLE) begin
      if (hit(`PFE_IDX_ADDR_LOW)) begin
        addr_low <= wbyte;
      end
      if (hit(`PFE_IDX_ADDR_HIGH)) begin
        addr_high <= wbyte[6:0];
      end
    end
  end

  // control register bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_sel <= 1'b0;
      lat_only <= 1'b0;
      erase_sel <= 1'b0;
      arm <= 1'b0;
    end else if (wr && hit(`PFE_IDX_CONTROL) && state == PFE_IDLE) begin
      cfg_sel <= wbyte[`PFE_BIT_CFGSEL];
      lat_only <= wbyte[`PFE_BIT_LATONLY];
      erase_sel <= wbyte[`PFE_BIT_ERASE];
      arm <= wbyte[`PFE_BIT_ARM];
    end
  end

  // fault flag: go refused is a fault; set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault <= 1'b0;
    end else if (wr && hit(`PFE_IDX_CONTROL) && wbyte[`PFE_BIT_GO]
                 && !start && state == PFE_IDLE) begin
      fault <= 1'b1;
    end else if (wr && hit(`PFE_IDX_CONTROL) && state == PFE_IDLE) begin
      fault <= wbyte[`PFE_BIT_FAULT];
    end
  end

  // go bit, cleared by hardware at end of erase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go <= 1'b0;
    end else if (start) begin
      go <= 1'b1;
    end else if (state == PFE_ERASE && cnt == 32'd0) begin
      go <= 1'b0;
    end
  end

  // ============================================================
  // unlock key tracker: any other write or a start resets it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_stage <= 2'd0;
    end else if (start) begin
      key_stage <= 2'd0;
    end else if (wr && hit(`PFE_IDX_UNLOCK)) begin
      if (wbyte == `PFE_KEY_FIRST) begin
        key_stage <= 2'd1;
      end else if (wbyte == `PFE_KEY_SECOND && key_stage == 2'd1) begin
        key_stage <= 2'd2;
      end else begin
        key_stage <= 2'd0;
      end
    end else if (wr) begin
      key_stage <= 2'd0;
    end
  end

  // ============================================================
  // sequencer: setup then erase, counter counts down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PFE_IDLE;
      cnt <= 32'd0;
    end else begin
      case (state)
        PFE_IDLE: begin
          if (start) begin
            state <= PFE_SETUP;
            cnt <= 32'(`PFE_SETUP_CYC - 1);
          end
        end
        PFE_SETUP: begin
          if (cnt == 32'd0) begin
            state <= PFE_ERASE;
            cnt <= ERASE_CYC - 32'd1;
          end else begin
            cnt <= cnt - 32'd1;
          end
        end
        PFE_ERASE: begin
          if (cnt == 32'd0) begin
            state <= PFE_IDLE;
          end else begin
            cnt <= cnt - 32'd1;
          end
        end
        default: state <= PFE_IDLE;
      endcase
    end
  end

  // stall only during erase; clock never gated, no sleep
  assign stall_o = (state == PFE_ERASE);
  assign busy_o = (state != PFE_IDLE);

  // row address with low bits forced to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_o <= '0;
    end else begin
      erase_o.req <= (state == PFE_SETUP && cnt == 32'd0)
        || (state == PFE_ERASE && cnt != 32'd0);
      erase_o.row_addr <= {addr_high, addr_low[7:`PFE_ROW_BITS],
        `PFE_ROW_BITS'(0)};
    end
  end

  // ============================================================
  // assertions
  // all sampled on the system clock, quiet during reset

  // helper: stall cycles counted so far, still holding the full length in the cycle after the stall, then zero
  logic [31:0] stall_len;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stall_len <= 32'd0;
    end else if (stall_o) begin
      stall_len <= stall_len + 32'd1;
    end else begin
      stall_len <= 32'd0;
    end
  end

  // go refused without the full unlock key
  a_go_blocked_no_key: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && hit(`PFE_IDX_CONTROL) && wbyte[`PFE_BIT_GO]
    && key_stage != 2'd2 && state == PFE_IDLE) |=> state == PFE_IDLE)
    else $error("start without unlock");
  // go refused while the arm bit is clear
  a_arm_blocks_go: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && hit(`PFE_IDX_CONTROL) && wbyte[`PFE_BIT_GO]
    && !wbyte[`PFE_BIT_ARM] && state == PFE_IDLE) |=> state == PFE_IDLE)
    else $error("start without arm");
  // a refused go leaves the fault flag set
  a_fault_on_refusal: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && hit(`PFE_IDX_CONTROL) && wbyte[`PFE_BIT_GO] && !start
    && state == PFE_IDLE) |=> fault)
    else $error("refused go without fault");

  // exactly two setup cycles before the erase
  a_setup_two_cycles: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start |=> state == PFE_SETUP ##1 state == PFE_SETUP
    ##1 state == PFE_ERASE)
    else $error("setup not two cycles");
  // an accepted go sets the go bit
  a_start_sets_go: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start |=> go)
    else $error("go not set on start");
  // the key is spent by the start it allowed
  a_key_spent_start: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start |=> key_stage == 2'd0)
    else $error("key survives a start");

  // stall only ever entered from setup
  a_stall_in_erase: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(stall_o) |-> $past(state) == PFE_SETUP)
    else $error("stall without setup");
  // stall lasts exactly the erase time
  a_stall_length: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(stall_o) |-> stall_len == ERASE_CYC)
    else $error("stall length wrong");
  // flash erase request coincides with the stall
  a_req_with_stall: assert property (
    @(posedge clk_i) disable iff (rst_i)
    erase_o.req == stall_o)
    else $error("erase request off the stall");
  // go clears itself as the erase ends
  a_go_clears_end: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(stall_o) |-> !go)
    else $error("go stays after erase");
  // go stands exactly while the sequencer is busy
  a_go_tracks_busy: assert property (
    @(posedge clk_i) disable iff (rst_i)
    go == busy_o)
    else $error("go and busy disagree");
  // core released straight to idle after the stall
  a_resume_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(stall_o) |-> state == PFE_IDLE && !busy_o)
    else $error("no resume after erase");

  // erased row has its low address bits clear
  a_row_aligned: assert property (
    @(posedge clk_i) disable iff (rst_i)
    erase_o.req |-> erase_o.row_addr[`PFE_ROW_BITS-1:0] == '0)
    else $error("erase not row aligned");
  // erased row is the one holding the loaded address
  a_row_from_addr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    erase_o.req |-> erase_o.row_addr[14:`PFE_ROW_BITS]
    == {addr_high, addr_low[7:`PFE_ROW_BITS]})
    else $error("erase row not the loaded one");

  // unused top bits read back as one
  a_top_bits_one: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_i.we && (hit(`PFE_IDX_CONTROL) || hit(`PFE_IDX_ADDR_HIGH)))
    |=> rdat[7])
    else $error("top bit not one");
  // key accepted only as the first byte then the second
  a_key_order: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(key_stage == 2'd2) |-> $past(key_stage) == 2'd1)
    else $error("key accepted out of order");
  // ack is a single cycle pulse
  a_ack_one_cycle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack |=> !ack)
    else $error("ack longer than a cycle");
  // register bus keeps answering through the stall
  a_bus_alive_stall: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (stall_o && req) |=> ack)
    else $error("bus dead in stall");

  // main scenarios
  c_erase_done: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(stall_o));
  c_refused_go: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(fault));
  c_unlock: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(key_stage == 2'd2));
  c_bus_in_stall: cover property (@(posedge clk_i) disable iff (rst_i)
    stall_o && ack);
endmodule

// ### hdl/pfe_map.svh
// register offsets, field positions, reset values and timing counts
// assumes a word-addressed classic wishbone slave, 200 MHz system clock
`ifndef PFE_MAP_SVH
`define PFE_MAP_SVH
// ============================================================
// register indices (byte address is four times the index)
`define PFE_IDX_ADDR_LOW 12'h191
`define PFE_IDX_ADDR_HIGH 12'h192
`define PFE_IDX_DATA_LOW 12'h193
`define PFE_IDX_DATA_HIGH 12'h194
`define PFE_IDX_CONTROL 12'h195
`define PFE_IDX_UNLOCK 12'h196
// ============================================================
// control register fields
`define PFE_BIT_CFGSEL 6
`define PFE_BIT_LATONLY 5
`define PFE_BIT_ERASE 4
`define PFE_BIT_FAULT 3
`define PFE_BIT_ARM 2
`define PFE_BIT_GO 1
`define PFE_BIT_READ 0
// ============================================================
// reset values
`define PFE_RST_ADDR_LOW 8'h00
`define PFE_RST_ADDR_HIGH 8'h80
`define PFE_RST_CONTROL 8'h80
`define PFE_RST_UNLOCK 8'h00
// ============================================================
// unlock key bytes
`define PFE_KEY_FIRST 8'h55
`define PFE_KEY_SECOND 8'haa
// ============================================================
// timing: erase time in microseconds, clock in MHz
`define PFE_ERASE_US 2000
`define PFE_CLK_MHZ 200
`define PFE_ERASE_CYC (`PFE_ERASE_US * `PFE_CLK_MHZ)
`define PFE_SETUP_CYC 2
// row size as log2 of its words (low address bits ignored for erase)
`define PFE_ROW_BITS 4
`endif

// ### hdl/pfe_pkg.sv
// types for the program flash row erase sequencer
// assumes pfe_map.svh for numeric constants
package pfe_pkg;
  typedef enum logic [1:0] {
    PFE_IDLE,
    PFE_SETUP,
    PFE_ERASE
  } pfe_state_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pfe_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pfe_wb_rsp_t;
  typedef struct packed {
    logic req;
    logic [14:0] row_addr;
  } pfe_erase_t;
endpackage

// ### bench/pfe_core_model.sv
// core model: counts executed instructions and peripheral ticks
// assumes stall_i from the sequencer, same clock and reset
`timescale 1ns/100ps
module pfe_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // halt request from the sequencer
  input wire logic stall_i,
  // progress counters
  output logic [15:0] instr_o,
  output logic [15:0] tick_o
);
  // ==========================================
  // fetch halts only while stalled; the two nops after go still run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_o <= 16'h0000;
    end else if (!stall_i) begin
      instr_o <= instr_o + 16'h0001;
    end
  end
  // peripherals keep counting through the stall
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 16'h0000;
    end else begin
      tick_o <= tick_o + 16'h0001;
    end
  end
endmodule

// ### bench/program_flash_row_erase_tb.sv
// testbench for the program flash row erase sequencer
// assumes the core model beside it and a 200 MHz clock
`timescale 1ns/100ps
`include "pfe_map.svh"
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module program_flash_row_erase_tb;
  import pfe_pkg::*;
  localparam int unsigned ECYC = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  pfe_wb_req_t wb_i = '0;
  pfe_wb_rsp_t wb_o;
  logic stall_o;
  logic busy_o;
  pfe_erase_t erase_o;
  logic [15:0] instr, tick, i0, t0;
  logic [31:0] rd;
  logic [14:0] row;
  int num_errors = 0;
  int comparisons = 0;
  int cyc_n = 0;
  int nb, ns, nr;
  // key, key, control tries that must not start
  logic [7:0] bad [5][3] = '{'{8'h55, 8'haa, 8'h12},
    '{8'haa, 8'h55, 8'h16}, '{8'h55, 8'h55, 8'h16},
    '{8'h55, 8'haa, 8'h56}, '{8'h55, 8'haa, 8'h06}};
  // ==========================================
  // design and core model
  pfe_row_erase #(.ERASE_CYC(ECYC)) pfe_row_erase_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .stall_o(stall_o),
    .erase_o(erase_o), .busy_o(busy_o));
  pfe_core_model pfe_core_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .stall_i(stall_o), .instr_o(instr), .tick_o(tick));
  // clock and hang guard
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ==========================================
  // compare and report
  task automatic check(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [11:0] a,
                    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1,
              dat: {24'h0, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 20);
    `CHK("ack", 1'b1, wb_o.ack);
    rd = wb_o.dat;
    wb_i <= '0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK($sformatf("reg %h", a), e, rd);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(`PFE_IDX_ADDR_LOW, `PFE_RST_ADDR_LOW);
    rchk(`PFE_IDX_ADDR_HIGH, 8'h80);
    rchk(`PFE_IDX_CONTROL, 8'h80);
    rchk(12'h1a0, 8'h00);
    wb(1'b1, `PFE_IDX_ADDR_HIGH, 8'h05);
    rchk(`PFE_IDX_ADDR_HIGH, 8'h85);
    wb(1'b1, `PFE_IDX_ADDR_LOW, 8'h37);
    // bad key, order, arm, space or erase select
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, `PFE_IDX_UNLOCK, bad[i][0]);
      wb(1'b1, `PFE_IDX_UNLOCK, bad[i][1]);
      wb(1'b1, `PFE_IDX_CONTROL, bad[i][2]);
      repeat (3) @(posedge clk_i);
      `CHK("busy", 1'b0, busy_o);
      wb(1'b0, `PFE_IDX_CONTROL, 8'h00);
      `CHK("fault", 1'b1, rd[3]);
    end
    // proper unlock, then erase with a write during the stall
    wb(1'b1, `PFE_IDX_UNLOCK, `PFE_KEY_FIRST);
    wb(1'b1, `PFE_IDX_UNLOCK, `PFE_KEY_SECOND);
    nb = 0;
    ns = 0;
    nr = 0;
    i0 = instr;
    t0 = tick;
    fork
      repeat (60) @(posedge clk_i) begin
        nb += (busy_o === 1'b1);
        ns += (stall_o === 1'b1);
        nr += (erase_o.req === 1'b1);
        if (erase_o.req === 1'b1) row = erase_o.row_addr;
      end
      begin
        wb(1'b1, `PFE_IDX_CONTROL, 8'h16);
        wait (stall_o === 1'b1);
        wb(1'b1, `PFE_IDX_ADDR_LOW, 8'hff);
      end
    join
    `CHK("stall cycles", ECYC, ns);
    `CHK("erase cycles", ECYC, nr);
    `CHK("setup cycles", 2, nb - ns);
    `CHK("row", 15'h0530, row);
    `CHK("core steps", 60 - ns, 16'(instr - i0));
    `CHK("ticks", 60, 16'(tick - t0));
    rchk(`PFE_IDX_ADDR_LOW, 8'h37);
    wb(1'b0, `PFE_IDX_CONTROL, 8'h00);
    `CHK("go", 1'b0, rd[1]);
    tally_and_finish();
  end
endmodule
